/* File: pkg/pcf_pkg.sv */
// package for the clock fan-out block: constants, modes and output bundle
package pcf_pkg;

    // divider chain width and bit taps (ratio = 2**(tap+1) of the vco-rate chain)
    localparam int DIV_WIDTH = 4;
    localparam logic [DIV_WIDTH-1:0] DIV_RESET = 4'h0;
    localparam int TAP_DOUBLE = 0;
    localparam int TAP_BASE = 1;
    localparam int TAP_HALF = 2;

    // feedback wiring choices, fixing output-to-reference ratio
    typedef enum logic [1:0] {
        FB_HALF,
        FB_BASE,
        FB_DOUBLE
    } pcf_fb_sel_t;

    // chain steps per reference period for each feedback choice
    localparam logic [3:0] VCO_MUL_HALF = 4'h8;
    localparam logic [3:0] VCO_MUL_BASE = 4'h4;
    localparam logic [3:0] VCO_MUL_DOUBLE = 4'h2;

    // chain wraps after eight steps, one half-rate period
    localparam logic [DIV_WIDTH-1:0] CHAIN_WRAP = 4'h7;

    // reference period measured in vco cycles, saturating
    localparam int PER_WIDTH = 8;
    localparam logic [PER_WIDTH-1:0] PER_DEFAULT = 8'h10;
    localparam logic [PER_WIDTH-1:0] PER_ONE = 8'h01;
    localparam logic [PER_WIDTH-1:0] ACC_RESET = 8'h00;

    // all clock outputs travel together
    typedef struct packed {
        logic doubleRateOut;
        logic [4:0] baseRateOuts;
        logic invertedBaseOut;
        logic halfRateOut;
    } pcf_clk_outs_t;

endpackage : pcf_pkg

/* File: hw/pcf_fanout.sv */
// clock fan-out with divider chain, locked mode model and bypass test mode
// Functional notes
// - feedback rising edges aligned to reference rising
// - half-rate feedback: base 2x, double 4x
// - base four feedback: base equals reference
// - double-rate feedback: double equals reference
// - any base output fed back: base equals reference
// - loop-enable low bypasses the oscillator
// - test, select high: invert, div2 falling, div4
// - test, select low: div2, div4, div8
// - reference-select low picks reference zero
// - test mode takes any reference frequency
`timescale 1ns/1ns
`default_nettype none

module pcf_fanout
    import pcf_pkg::*;
(
    // system clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // fast oscillator clock standing in for the vco
    input wire logic clk_vco,
    // reference clocks and their select
    input wire logic referenceInputZero,
    input wire logic referenceInputOne,
    input wire logic referenceSelect,
    // loop control
    input wire logic loopEnable,
    input wire logic vcoDivideSelect,
    input wire pcf_fb_sel_t feedbackSelect,
    // clock outputs and the test-mode status flag
    output pcf_clk_outs_t clkOuts,
    output logic testModeActive
);

    // selected reference, low select gives input zero
    wire logic refSel = referenceSelect ? referenceInputOne
                                        : referenceInputZero;

    // ------------------------------------------------------------------
    // system domain: only the status flag lives here
    // ------------------------------------------------------------------

    // loop-enable pin through two flops before the status flag reads it
    logic [1:0] enSys_reg; // [0] first stage, [1] second stage

    // status synchroniser; reset gives the bypass flag set
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            enSys_reg <= 2'h0;
        end else begin
            enSys_reg <= {enSys_reg[0], loopEnable};
        end
    end

    // test mode flag reported from synchronised loop-enable
    assign testModeActive = ~enSys_reg[1];

    // ------------------------------------------------------------------
    // vco domain: pin levels and the reference cross in here
    // ------------------------------------------------------------------

    // bundle order: reference, loop-enable, divide-select, feedback
    logic [4:0] ctlMeta_reg; // first stage, may go metastable
    logic [4:0] ctlSync_reg; // second stage, the only one logic reads
    logic refPrev_reg; // last synchronised reference level

    // feedback and divide-select are quasi-static straps, so a bit-wise
    // synchroniser is enough; a change settles within one reference period
    always_ff @(posedge clk_vco) begin
        ctlMeta_reg <= {refSel, loopEnable, vcoDivideSelect, feedbackSelect};
        ctlSync_reg <= ctlMeta_reg;
    end

    // named views of the synchronised bundle
    wire logic refSync = ctlSync_reg[4]; // reference in vco time
    wire logic vcoRun = ctlSync_reg[3]; // oscillator enabled
    wire logic divSelSync = ctlSync_reg[2]; // divide-select level
    wire pcf_fb_sel_t fbSync = pcf_fb_sel_t'(ctlSync_reg[1:0]);

    // reference rising edge as a one-cycle pulse in the vco domain
    wire logic refRise = refSync & ~refPrev_reg;

    // ------------------------------------------------------------------
    // locked-mode model: a digital stand-in for the loop
    // ------------------------------------------------------------------

    // chain bits: bit0 double rate, bit1 base rate, bit2 half rate
    logic [DIV_WIDTH-1:0] vcoDiv_reg;
    logic [DIV_WIDTH-1:0] vcoDiv_next;
    // set once the chain has made its steps for this period
    logic done_reg;
    logic done_next;
    // fractional step accumulator, spreads steps over the period
    logic [PER_WIDTH-1:0] acc_reg;
    logic [PER_WIDTH-1:0] acc_next;
    // vco cycles since the last reference rise, saturating
    logic [PER_WIDTH-1:0] perCnt_reg;
    logic [PER_WIDTH-1:0] perCnt_next;
    // last measured reference period, the lock target
    logic [PER_WIDTH-1:0] perLen_reg;
    logic [PER_WIDTH-1:0] perLen_next;

    // chain bits that make up one period of the fed-back output
    function automatic logic [DIV_WIDTH-1:0] phaseMask(input pcf_fb_sel_t f);
        case (f)
            FB_HALF: begin
                phaseMask = 4'h7;
            end
            FB_BASE: begin
                phaseMask = 4'h3;
            end
            FB_DOUBLE: begin
                phaseMask = 4'h1;
            end
            default: begin
                phaseMask = 4'h3;
            end
        endcase
    endfunction : phaseMask

    // chain steps per reference period, fixing the output ratio
    function automatic logic [3:0] stepFor(input pcf_fb_sel_t f);
        case (f)
            FB_HALF: begin
                stepFor = VCO_MUL_HALF;
            end
            FB_BASE: begin
                stepFor = VCO_MUL_BASE;
            end
            FB_DOUBLE: begin
                stepFor = VCO_MUL_DOUBLE;
            end
            default: begin
                stepFor = VCO_MUL_BASE;
            end
        endcase
    endfunction : stepFor

    // saturating increment; a very slow reference just pins the count
    function automatic logic [PER_WIDTH-1:0] satInc(
        input logic [PER_WIDTH-1:0] v
    );
        if (v == {PER_WIDTH{1'b1}}) begin
            satInc = v;
        end else begin
            satInc = v + PER_ONE;
        end
    endfunction : satInc

    // decode of the feedback choice
    wire logic [DIV_WIDTH-1:0] fbMask = phaseMask(fbSync);
    wire logic [3:0] stepNow = stepFor(fbSync);

    // accumulator arithmetic one bit wider so the sum cannot wrap
    wire logic [PER_WIDTH:0] perWide = {1'b0, perLen_reg};
    wire logic [PER_WIDTH:0] accSum = {1'b0, acc_reg} + {5'h00, stepNow};
    wire logic accWrap = accSum >= perWide;
    wire logic [PER_WIDTH:0] accLeft = accSum - perWide;

    // next chain values: one plain step, or a jump to the period start
    wire logic [DIV_WIDTH-1:0] chainInc = (vcoDiv_reg + 4'h1) & CHAIN_WRAP;
    wire logic [DIV_WIDTH-1:0] chainJump =
        ((vcoDiv_reg | fbMask) + 4'h1) & CHAIN_WRAP;
    // the fed-back output rises when its chain bits return to zero
    wire logic incDone = (chainInc & fbMask) == DIV_RESET;

    // next state of the locked model
    always_comb begin
        vcoDiv_next = vcoDiv_reg;
        done_next = done_reg;
        acc_next = acc_reg;
        perCnt_next = satInc(perCnt_reg);
        perLen_next = perLen_reg;
        if (!vcoRun) begin
            // oscillator off: park everything at a known point
            vcoDiv_next = DIV_RESET;
            done_next = 1'b0;
            acc_next = ACC_RESET;
            perCnt_next = PER_ONE;
            perLen_next = PER_DEFAULT;
        end else if (refRise) begin
            // finish a short period at once, so feedback rises now
            vcoDiv_next = done_reg ? vcoDiv_reg : chainJump;
            done_next = 1'b0;
            acc_next = ACC_RESET;
            perCnt_next = PER_ONE;
            perLen_next = perCnt_reg;
        end else if (!done_reg && accWrap) begin
            // one step of the chain; hold once the period is complete
            vcoDiv_next = chainInc;
            done_next = incDone;
            acc_next = accLeft[PER_WIDTH-1:0];
        end else if (!done_reg) begin
            // between steps: the fraction grows, the chain holds
            acc_next = accSum[PER_WIDTH-1:0];
        end
    end

    // vco domain state; the chain is parked while the oscillator is off
    always_ff @(posedge clk_vco) begin
        refPrev_reg <= refSync;
        vcoDiv_reg <= vcoDiv_next;
        done_reg <= done_next;
        acc_reg <= acc_next;
        perCnt_reg <= perCnt_next;
        perLen_reg <= perLen_next;
    end

    // ------------------------------------------------------------------
    // test mode: a plain synchronous counter divider on the selected reference
    // ------------------------------------------------------------------

    // falling-edge counter of the reference
    logic [DIV_WIDTH-1:0] tstDiv_reg;
    logic [DIV_WIDTH-1:0] tstDiv_next;

    // no timing of its own, so any reference rate works
    assign tstDiv_next = tstDiv_reg + 4'h1;

    // held clear while the loop runs, so test mode starts from zero;
    // the clear comes from a flop, so it cannot glitch
    always_ff @(negedge refSel or posedge vcoRun) begin
        if (vcoRun) begin
            tstDiv_reg <= DIV_RESET;
        end else begin
            tstDiv_reg <= tstDiv_next;
        end
    end

    // ------------------------------------------------------------------
    // output selection
    // ------------------------------------------------------------------

    // locked-mode outputs: chain bits, high first half of each period
    wire logic lkDouble = ~vcoDiv_reg[TAP_DOUBLE];
    wire logic lkBase = ~vcoDiv_reg[TAP_BASE];
    wire logic lkHalf = ~vcoDiv_reg[TAP_HALF];

    // test-mode outputs by divide-select
    wire logic tsDouble = divSelSync ? ~refSel
                                     : tstDiv_reg[0];
    wire logic tsBase = divSelSync ? tstDiv_reg[0]
                                   : tstDiv_reg[1];
    wire logic tsHalf = divSelSync ? tstDiv_reg[1]
                                   : tstDiv_reg[2];

    // mode select: loop-enable low is the static bypass
    wire logic outDouble = vcoRun ? lkDouble : tsDouble;
    wire logic outBase = vcoRun ? lkBase : tsBase;
    wire logic outHalf = vcoRun ? lkHalf : tsHalf;

    // output group; inverted output is always the complement
    assign clkOuts.doubleRateOut = outDouble;
    assign clkOuts.baseRateOuts = {5{outBase}};
    assign clkOuts.invertedBaseOut = ~outBase;
    assign clkOuts.halfRateOut = outHalf;

endmodule : pcf_fanout

`default_nettype wire

/* File: test/pcf_ref_source.sv */
// reference clock source with an uneven duty cycle
`timescale 1ns/1ns
`default_nettype none
module pcf_ref_source #(parameter int HI = 50, parameter int LO = 70) (
    output logic refClk // free-running reference, never 50% duty
);
    initial refClk = 1'h0;
    always #(refClk ? HI : LO) refClk = !refClk;
endmodule : pcf_ref_source
`default_nettype wire

/* File: test/pcf_fanout_checker.sv */
// assertion checker bound to the clock fan-out top module
`timescale 1ns/1ns
`default_nettype none
module pcf_fanout_checker
    import pcf_pkg::*;
(
    // clock, reset and mode inputs
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic referenceInputZero,
    input wire logic referenceSelect,
    input wire logic loopEnable,
    input wire logic vcoDivideSelect,
    // outputs under watch
    input wire pcf_clk_outs_t clkOuts,
    input wire logic testModeActive
);
    logic [3:0] warm_reg; // dividers start unknown, so wait them out
    logic off, tHi, tLo, b0, hf, db;
    assign off = sys_rst || warm_reg != 4'hF;
    logic [3:0] age_reg; // cycles since the mode pins last moved
    logic [2:0] mode_reg; // mode pins one cycle ago
    logic calm; // mode pins quiet long enough for both domains
    assign calm = age_reg == 4'hF;
    assign tHi = calm && testModeActive && !referenceSelect && vcoDivideSelect;
    assign tLo = calm && testModeActive && !referenceSelect
        && !vcoDivideSelect;
    // restart the age count whenever a mode pin moves
    always_ff @(posedge clk_sys) begin
        mode_reg <= {loopEnable, referenceSelect, vcoDivideSelect};
        if (sys_rst || mode_reg != {loopEnable, referenceSelect,
            vcoDivideSelect}) age_reg <= 4'h0;
        else if (!calm) age_reg <= age_reg + 4'h1;
    end
    assign b0 = clkOuts.baseRateOuts[0];
    assign hf = clkOuts.halfRateOut;
    assign db = clkOuts.doubleRateOut;
    // saturating warm-up count
    always_ff @(posedge clk_sys) begin
        if (sys_rst) warm_reg <= 4'h0;
        else if (off) warm_reg <= warm_reg + 4'h1;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (off);
    chk_inv_base: assert property (clkOuts.invertedBaseOut != b0)
        else $error("inverted output wrong");
    chk_base_same: assert property (clkOuts.baseRateOuts == {5{b0}})
        else $error("base outputs differ");
    chk_test_entry: assert property ($fell(loopEnable) |-> ##[1:3]
        testModeActive) else $error("test mode late");
    chk_dbl_inverse: assert property (tHi && !loopEnable |->
        db != referenceInputZero) else $error("double not inverse");
    chk_base_div2: assert property (@(negedge referenceInputZero)
        tHi [*2] |-> b0 != $past(b0)) else $error("base not div2");
    chk_half_div4: assert property (@(negedge referenceInputZero)
        tHi [*3] |-> hf != $past(hf, 2)) else $error("half not div4");
    chk_dbl_div2: assert property (@(negedge referenceInputZero)
        tLo [*2] |-> db != $past(db)) else $error("double not div2");
    chk_base_div4: assert property (@(negedge referenceInputZero)
        tLo [*3] |-> b0 != $past(b0, 2)) else $error("base not div4");
    cover property (tHi);
    cover property (tLo);
    cover property (!testModeActive && loopEnable);
endmodule : pcf_fanout_checker
bind pcf_fanout pcf_fanout_checker u_chk (.clk_sys, .sys_rst,
    .referenceInputZero, .referenceSelect, .loopEnable, .vcoDivideSelect,
    .clkOuts, .testModeActive);
`default_nettype wire

/* File: test/pcf_fanout_tb.sv */
// bench for the clock fan-out block: locked ratios and test divides
`timescale 1ns/1ns
`default_nettype none
module pcf_fanout_tb;
    import pcf_pkg::*;
    logic clk_sys = 1'h0, sys_rst = 1'h1, clk_vco = 1'h0, loopEnable = 1'h0;
    logic referenceSelect = 1'h0, vcoDivideSelect = 1'h1;
    pcf_fb_sel_t feedbackSelect = FB_HALF;
    wire logic referenceInputZero, referenceInputOne, testModeActive, selRef;
    pcf_clk_outs_t clkOuts;
    int n_mismatch = 0, checks_done = 0, cyc = 0, nD, nB, nH;
    assign selRef = referenceSelect ? referenceInputOne : referenceInputZero;
    always #5 clk_sys = !clk_sys;
    always #6 clk_vco = !clk_vco; // vco stand-in clock, phase unrelated
    // slow uneven reference for test mode, faster one for the loop
    pcf_ref_source #(.HI(170), .LO(230)) u_ref0 (.refClk(referenceInputZero));
    pcf_ref_source #(.HI(72), .LO(120)) u_ref1 (.refClk(referenceInputOne));
    pcf_fanout u_dut (.clk_sys, .sys_rst, .clk_vco, .referenceInputZero,
        .referenceInputOne, .referenceSelect, .loopEnable, .vcoDivideSelect,
        .feedbackSelect, .clkOuts, .testModeActive);
    // rising-edge counters for the frequency windows
    always @(posedge clkOuts.doubleRateOut) nD++;
    always @(posedge clkOuts.baseRateOuts[2]) nB++;
    always @(posedge clkOuts.halfRateOut) nH++;
    task automatic check(input int seen, input int want);
        checks_done++;
        if (seen != want) n_mismatch++;
        if (seen != want) $display("ERROR %0t saw %0d want %0d", $time, seen, want);
    endtask : check
    // set mode, settle, count edges over eight reference periods
    task automatic run(input logic le, ds, input pcf_fb_sel_t fb,
        input int d, b, h);
        @(posedge clk_sys);
        #1;
        {loopEnable, referenceSelect} = {le, le};
        {vcoDivideSelect, feedbackSelect} = {ds, fb};
        repeat (3) @(posedge selRef);
        {nD, nB, nH} = 0;
        repeat (8) @(posedge selRef);
        check(nD, d);
        check(nB, b);
        check(nH, h);
    endtask : run
    task automatic locked_ratios();
        run(1'h1, 1'h1, FB_HALF, 32, 16, 8);
        run(1'h1, 1'h1, FB_BASE, 16, 8, 4);
        run(1'h1, 1'h1, FB_DOUBLE, 8, 4, 2);
    endtask : locked_ratios
    task automatic test_divides();
        run(1'h0, 1'h1, FB_HALF, 8, 4, 2);
        run(1'h0, 1'h0, FB_BASE, 4, 2, 1);
        check(testModeActive === 1'h1, 1);
    endtask : test_divides
    task automatic give_verdict();
        if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict
    // hang guard: the run needs about 1500 cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 4000) check(cyc, 0);
        if (cyc == 4000) give_verdict();
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        #1 sys_rst = 1'h0;
        locked_ratios();
        test_divides();
        give_verdict();
    end
endmodule : pcf_fanout_tb
`default_nettype wire
